// file: src/sbpr_pkg.sv
// Package: constants and types shared by both ends of the base register bank
package sbpr_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] ADDR_NODE_ROOT = 4'h0;
  localparam logic [3:0] ADDR_HOLD_GAP  = 4'h1;
  localparam logic [3:0] ADDR_BASE_LAST = 4'h7;
  localparam logic [3:0] ADDR_PAGE_REG  = 4'h7;
  // ----------------------------------------
  // Field positions (bit 7 is the leftmost printed bit 0)
  // ----------------------------------------
  localparam int NODE_ADDR_LSB  = 2;
  localparam int ROOT_BIT       = 1;
  localparam int CPS_BIT        = 0;
  localparam int HOLDOFF_BIT    = 7;
  localparam int LONG_RST_BIT   = 6;
  localparam int GAP_LSB        = 0;
  localparam int PAGE_LSB       = 5;
  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [5:0] GAP_RESET      = 6'h3F;
  localparam logic [5:0] NODE_ADDR_RST  = 6'h3F;
  localparam int         CLK_MHZ        = 50;
  localparam int         LONG_RESET_US  = 166;
  localparam int         LONG_RESET_CYC = LONG_RESET_US * CLK_MHZ;
  localparam logic [13:0] LONG_RESET_CNT = 14'(LONG_RESET_CYC);
  // ----------------------------------------
  // Host command state
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    SBPR_H_IDLE = 3'b001,
    SBPR_H_WAIT = 3'b010,
    SBPR_H_DONE = 3'b100
  } sbpr_hstate_type;
endpackage

// file: src/sbpr_if.sv
// Interface: register access path between link controller and PHY register bank
interface sbpr_if;
  import sbpr_pkg::*;
  logic       req;
  logic       wr;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;
  logic       status_xfer;
  modport dev (input req, input wr, input addr, input wdata,
               output ack, output rdata, output status_xfer);
  modport host (output req, output wr, output addr, output wdata,
                input ack, input rdata, input status_xfer);
endinterface

// file: src/sbpr_device.sv
// Module: PHY base register bank, node address, root, holdoff, long reset and gap count
module sbpr_device
  import sbpr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // Register access from link
  sbpr_if.dev             bus,
  // Pins and physical layer events
  input  wire logic       cable_power_status_i,
  input  wire logic       bus_reset_i,
  input  wire logic       self_id_done_i,
  input  wire logic [5:0] self_id_addr_i,
  input  wire logic       became_root_i,
  input  wire logic       cfg_pkt_i,
  input  wire logic       cfg_holdoff_i,
  input  wire logic       cfg_gap_valid_i,
  input  wire logic [5:0] cfg_gap_i,
  input  wire logic       port_busy_i,
  input  wire logic [7:0] paged_rdata_i,
  // Outputs to physical layer
  output logic [5:0]      gap_count_o,
  output logic            root_holdoff_o,
  output logic            long_reset_active_o,
  output logic [2:0]      page_select_o
);
  import sbpr_pkg::*;

  typedef struct packed {
    logic [1:0]  cps_sync;
    logic [5:0]  node_address;
    logic        root;
    logic        root_holdoff;
    logic        long_reset_request;
    logic [5:0]  gap_count;
    logic        gap_written;
    logic        prior_reset_seen;
    logic        long_active;
    logic [13:0] long_cnt;
    logic [2:0]  page;
    logic        ack;
    logic [7:0]  rdata;
    logic        status_xfer;
  } sbpr_dev_type;

  sbpr_dev_type st_ff;
  sbpr_dev_type nxt_st;
  logic         reg_wr;
  logic         hold_gap_wr;
  logic         gap_upd;
  logic         any_bus_reset;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign reg_wr        = bus.req && bus.wr;
  assign hold_gap_wr   = reg_wr && (bus.addr == ADDR_HOLD_GAP);
  // Any gap update, by register or by configuration packet, restarts the idle-reset count
  assign gap_upd       = hold_gap_wr || (cfg_pkt_i && cfg_gap_valid_i);
  // The end of our own long reset counts as a bus reset for every side effect
  assign any_bus_reset = bus_reset_i || (st_ff.long_active && st_ff.long_cnt == 14'h0001);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    // Cable power is a pin level; two flops keep a slow edge out of the read path
    nxt_st.cps_sync = {st_ff.cps_sync[0], cable_power_status_i};
    nxt_st.ack = 1'b0;
    nxt_st.status_xfer = 1'b0;
    // Self-ID result and unsolicited register 0 report
    if (self_id_done_i)
    begin
      nxt_st.node_address = self_id_addr_i;
      nxt_st.status_xfer  = 1'b1;
    end
    if (became_root_i)
    begin
      nxt_st.root = 1'b1;
    end
    // Register writes; address 0 is read-only so nothing lands there
    if (hold_gap_wr)
    begin
      nxt_st.root_holdoff       = bus.wdata[HOLDOFF_BIT];
      nxt_st.long_reset_request = bus.wdata[LONG_RST_BIT];
      nxt_st.gap_count          = bus.wdata[GAP_LSB +: 6];
      nxt_st.gap_written        = 1'b1;
    end
    if (reg_wr && bus.addr == ADDR_PAGE_REG)
    begin
      nxt_st.page = bus.wdata[PAGE_LSB +: 3];
    end
    // Configuration packet sent or received
    if (cfg_pkt_i)
    begin
      nxt_st.root_holdoff = cfg_holdoff_i;
      if (cfg_gap_valid_i)
      begin
        nxt_st.gap_count   = cfg_gap_i;
        nxt_st.gap_written = 1'b1;
      end
    end
    // Wait for traffic to finish, then drive a long reset
    if (st_ff.long_reset_request && !st_ff.long_active && !port_busy_i)
    begin
      nxt_st.long_active = 1'b1;
      nxt_st.long_cnt    = LONG_RESET_CNT;
    end
    if (st_ff.long_active)
    begin
      nxt_st.long_cnt = st_ff.long_cnt - 14'h0001;
      if (st_ff.long_cnt == 14'h0001)
      begin
        nxt_st.long_active = 1'b0;
      end
    end
    // Bus reset side effects; holdoff is left alone
    if (any_bus_reset)
    begin
      nxt_st.root               = 1'b0;
      // A write landing with the reset is kept: the set wins over the clear
      nxt_st.long_reset_request = hold_gap_wr && bus.wdata[LONG_RST_BIT];
      nxt_st.node_address       = NODE_ADDR_RST;
      nxt_st.gap_written        = gap_upd;
      nxt_st.prior_reset_seen   = 1'b1;
      // Second reset since the last gap update restores the default
      if (st_ff.prior_reset_seen && !st_ff.gap_written && !gap_upd)
      begin
        nxt_st.gap_count = GAP_RESET;
      end
    end
    // Read answer, one cycle after request
    // Reads have no side effects, so the host may re-read any register freely
    if (bus.req)
    begin
      nxt_st.ack   = 1'b1;
      nxt_st.rdata = 8'h00;
      case (bus.addr)
        ADDR_NODE_ROOT:
        begin
          nxt_st.rdata[NODE_ADDR_LSB +: 6] = st_ff.node_address;
          nxt_st.rdata[ROOT_BIT]           = st_ff.root;
          nxt_st.rdata[CPS_BIT]            = st_ff.cps_sync[1];
        end
        ADDR_HOLD_GAP:
        begin
          nxt_st.rdata[HOLDOFF_BIT]  = st_ff.root_holdoff;
          nxt_st.rdata[LONG_RST_BIT] = st_ff.long_reset_request;
          nxt_st.rdata[GAP_LSB +: 6] = st_ff.gap_count;
        end
        ADDR_PAGE_REG:
        begin
          nxt_st.rdata[PAGE_LSB +: 3] = st_ff.page;
        end
        default:
        begin
          if (bus.addr > ADDR_BASE_LAST)
          begin
            nxt_st.rdata = paged_rdata_i;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      st_ff           <= '0;
      st_ff.gap_count <= GAP_RESET;
      st_ff.node_address <= NODE_ADDR_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign bus.ack             = st_ff.ack;
  assign bus.rdata           = st_ff.rdata;
  assign bus.status_xfer     = st_ff.status_xfer;
  assign gap_count_o         = st_ff.gap_count;
  assign root_holdoff_o      = st_ff.root_holdoff;
  assign long_reset_active_o = st_ff.long_active;
  assign page_select_o       = st_ff.page;
endmodule

// file: src/sbpr_host.sv
// Module: link-side access engine for the PHY base register bank
module sbpr_host
  import sbpr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // User command port
  input  wire logic       cmd_valid_i,
  input  wire logic       cmd_wr_i,
  input  wire logic [3:0] cmd_addr_i,
  input  wire logic [7:0] cmd_wdata_i,
  output logic            cmd_ready_o,
  output logic            cmd_done_o,
  output logic [7:0]      cmd_rdata_o,
  output logic            status_seen_o,
  // Register access to PHY
  sbpr_if.host            bus
);
  import sbpr_pkg::*;

  typedef struct packed {
    sbpr_hstate_type state;
    logic            wr;
    logic [3:0]      addr;
    logic [7:0]      wdata;
    logic            done;
    logic [7:0]      rdata;
    logic            status_seen;
  } sbpr_host_type;

  sbpr_host_type st_ff;
  sbpr_host_type nxt_st;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    nxt_st.status_seen = bus.status_xfer;
    case (st_ff.state)
      SBPR_H_IDLE:
      begin
        if (cmd_valid_i)
        begin
          // Caller must merge long reset writes with current holdoff and gap
          nxt_st.wr    = cmd_wr_i;
          nxt_st.addr  = cmd_addr_i;
          nxt_st.wdata = cmd_wdata_i;
          nxt_st.state = SBPR_H_WAIT;
        end
      end
      SBPR_H_WAIT:
      begin
        if (bus.ack)
        begin
          nxt_st.rdata = bus.rdata;
          nxt_st.done  = 1'b1;
          nxt_st.state = SBPR_H_DONE;
        end
      end
      SBPR_H_DONE:
      begin
        nxt_st.state = SBPR_H_IDLE;
      end
      default:
      begin
        nxt_st.state = SBPR_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      st_ff       <= '0;
      st_ff.state <= SBPR_H_IDLE;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Request held one cycle per command; device acks on the following edge
  assign bus.req       = (st_ff.state == SBPR_H_WAIT) && !bus.ack;
  assign bus.wr        = st_ff.wr;
  assign bus.addr      = st_ff.addr;
  assign bus.wdata     = st_ff.wdata;
  assign cmd_ready_o   = (st_ff.state == SBPR_H_IDLE);
  assign cmd_done_o    = st_ff.done;
  assign cmd_rdata_o   = st_ff.rdata;
  assign status_seen_o = st_ff.status_seen;
endmodule

// file: testbench/sbpr_assertions.sv
// Checker: timing relations on the register access path between both ends
module sbpr_checker (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       resetn_i,
  // Interface signals
  input wire logic       req,
  input wire logic       wr,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata,
  input wire logic       status_xfer
);
  import sbpr_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence access_s;
    req ##1 ack;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  req_ack_a: assert property (req |-> access_s)
    else $error("ack did not follow request by one cycle");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("ack held longer than one cycle");
  ack_cause_a: assert property (ack |-> $past(req))
    else $error("ack without request");
  req_release_a: assert property (ack |-> !req)
    else $error("request still high with ack");
  req_single_a: assert property (req |=> !req)
    else $error("request held two cycles");
  access_gap_a: assert property (access_s |=> !req [*2])
    else $error("next request too soon after ack");
  status_pulse_a: assert property (status_xfer |=> !status_xfer)
    else $error("status report longer than one cycle");
  rdata_hold_a: assert property (!ack |-> $stable(rdata))
    else $error("read data changed outside an access");
  page_rsvd_a: assert property (ack && addr == ADDR_PAGE_REG |-> rdata[4:0] == 5'h00)
    else $error("reserved page register bits read nonzero");
endmodule

// file: testbench/serial_bus_phy_base_registers_bench.sv
// Testbench: both ends of the base register bank joined by their interface
module serial_bus_phy_base_registers_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import sbpr_pkg::*;
  logic       clk_i = 0, resetn_i = 0, cable_power_status = 1, brst = 0, sid_done = 0, root_ev = 0;
  logic       cfg = 0, cfg_hold = 0, cfg_gv = 0, busy = 0;
  logic [5:0] sid_addr = 0, cfg_gap = 0, g, gap_o;
  logic [7:0] paged = 0, cmd_wdata = 0, rdata, q, w;
  logic [2:0] pg;
  logic [3:0] cmd_addr = 0;
  logic       cmd_valid = 0, cmd_wr = 0, ready, done, seen, hold_o, lr_o;
  int         err_total = 0, checked = 0, n;
  sbpr_if link ();
  sbpr_device sbpr_device_inst (.clk_i(clk_i), .resetn_i(resetn_i), .bus(link),
    .cable_power_status_i(cable_power_status), .bus_reset_i(brst), .self_id_done_i(sid_done),
    .self_id_addr_i(sid_addr), .became_root_i(root_ev), .cfg_pkt_i(cfg),
    .cfg_holdoff_i(cfg_hold), .cfg_gap_valid_i(cfg_gv), .cfg_gap_i(cfg_gap),
    .port_busy_i(busy), .paged_rdata_i(paged), .gap_count_o(gap_o),
    .root_holdoff_o(hold_o), .long_reset_active_o(lr_o), .page_select_o(pg));
  sbpr_host sbpr_host_inst (.clk_i(clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid),
    .cmd_wr_i(cmd_wr), .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata), .cmd_ready_o(ready),
    .cmd_done_o(done), .cmd_rdata_o(rdata), .status_seen_o(seen), .bus(link));
  sbpr_checker sbpr_checker_inst (.clk_i(clk_i), .resetn_i(resetn_i), .req(link.req),
    .wr(link.wr), .addr(link.addr), .wdata(link.wdata), .ack(link.ack),
    .rdata(link.rdata), .status_xfer(link.status_xfer));
  always #10 clk_i = ~clk_i;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] r0(logic [5:0] a, logic r, logic c);
    return {a, r, c};
  endfunction
  function automatic logic [7:0] r1(logic h, logic l, logic [5:0] gv);
    return {h, l, gv};
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    checked++;
    if (e !== s)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One command through the host; waits for ready and done under a bound
  task automatic acc(logic w, logic [3:0] a, logic [7:0] d, output logic [7:0] r);
    int k;
    k = 0;
    @(negedge clk_i);
    while (ready !== 1'b1 && k++ < 20) @(negedge clk_i);
    @(posedge clk_i);
    cmd_valid <= 1; cmd_wr <= w; cmd_addr <= a; cmd_wdata <= d;
    @(posedge clk_i);
    cmd_valid <= 0;
    k = 0;
    do @(negedge clk_i); while (done !== 1'b1 && k++ < 20);
    if (done !== 1'b1)
    begin
      err_total++;
      $display("MISMATCH done expected 1 seen %b", done);
    end
    r = rdata;
  endtask
  task automatic bus_rst();
    @(posedge clk_i); brst <= 1;
    @(posedge clk_i); brst <= 0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic final_report();
    if (err_total == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Long reset alone is 8300 cycles; the rest needs a few hundred
  initial
  begin
    repeat (30000) @(posedge clk_i);
    err_total++;
    final_report();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    void'($urandom(94));
    repeat (3) @(posedge clk_i);
    resetn_i <= 1;
    acc(0, ADDR_HOLD_GAP, 0, q); chk("reg1 reset", r1(0, 0, 6'h3F), q);
    acc(0, ADDR_NODE_ROOT, 0, q); chk("reg0 reset", r0(6'h3F, 0, 1), q);
    @(posedge clk_i); cable_power_status <= 0;
    acc(1, ADDR_NODE_ROOT, 8'hFF, q); acc(0, ADDR_NODE_ROOT, 0, q);
    chk("reg0 ro", r0(6'h3F, 0, 0), q);
    for (int i = 0; i < 4; i++)
    begin
      g = (i == 0) ? 6'h00 : 6'($urandom);
      acc(1, ADDR_HOLD_GAP, r1(0, 0, g), q); acc(0, ADDR_HOLD_GAP, 0, q);
      chk("gap write", r1(0, 0, g), q);
    end
    g = 6'($urandom);
    @(posedge clk_i); cfg <= 1; cfg_hold <= 1; cfg_gv <= 1; cfg_gap <= g;
    @(posedge clk_i); cfg <= 0; cfg_gv <= 0;
    acc(0, ADDR_HOLD_GAP, 0, q); chk("cfg packet", r1(1, 0, g), q);
    chk("gap pin", {10'h000, g}, {10'h000, gap_o});
    chk("holdoff pin", 1, hold_o);
    bus_rst();
    acc(0, ADDR_HOLD_GAP, 0, q); chk("one bus reset", r1(1, 0, g), q);
    bus_rst();
    acc(0, ADDR_HOLD_GAP, 0, q); chk("two bus resets", r1(1, 0, 6'h3F), q);
    g = 6'($urandom);
    @(posedge clk_i); root_ev <= 1;
    @(posedge clk_i); root_ev <= 0; sid_addr <= g; sid_done <= 1;
    @(posedge clk_i); sid_done <= 0;
    n = 0;
    do @(negedge clk_i); while (seen !== 1'b1 && ++n < 10);
    chk("status seen", 1, seen);
    acc(0, ADDR_NODE_ROOT, 0, q); chk("self id", r0(g, 1, 0), q);
    bus_rst();
    acc(0, ADDR_NODE_ROOT, 0, q); chk("root cleared", r0(6'h3F, 0, 0), q);
    for (int a = 8; a < 16; a++)
    begin
      @(posedge clk_i);
      paged <= 8'($urandom);
      acc(0, 4'(a), 0, q); chk("paged read", paged, q);
    end
    w = 8'($urandom);
    acc(1, ADDR_PAGE_REG, w, q); acc(0, ADDR_PAGE_REG, 0, q);
    chk("page reg", {w[PAGE_LSB +: 3], 5'h00}, q);
    chk("page pin", w[PAGE_LSB +: 3], pg);
    // Long reset held off while the port is busy
    @(posedge clk_i); busy <= 1;
    acc(0, ADDR_HOLD_GAP, 0, q); acc(1, ADDR_HOLD_GAP, q | 8'h40, q);
    repeat (20) @(negedge clk_i);
    chk("long reset waits", 0, lr_o);
    @(posedge clk_i); busy <= 0;
    n = 0;
    while (lr_o !== 1'b1 && n++ < 5) @(negedge clk_i);
    n = 0;
    while (lr_o === 1'b1 && n < 9000)
    begin
      @(negedge clk_i);
      n++;
    end
    chk("long reset length", 16'(LONG_RESET_CYC), 16'(n));
    acc(0, ADDR_HOLD_GAP, 0, q); chk("long bit clear", r1(1, 0, 6'h3F), q);
    @(posedge clk_i); resetn_i <= 0;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1;
    acc(0, ADDR_HOLD_GAP, 0, q); chk("hw reset", r1(0, 0, 6'h3F), q);
    final_report();
  end
endmodule
